// File: pps_parallel_port.sv
// Purpose: Eight-line parallel port with latch, soft reset and combined status
// Assumes: Timer core is same-clock logic that reports its events as pulses
// Notes:   Registers on APB, zero wait states, all outputs from flip-flops
//
// Operation
// - Each register has its own address
// - Status is read-only, flags set by sources
// - Composite set by any enabled flag, any order
// - Composite and irq clear when enabled flags clear
// - Timer reset clears timer flag
// - Counter initialisation clears timer flag
// - Latch write clears timer flag in interval mode
// - Counter read clears only if status showed flag
// - Status bits 3 to 6 read zero
// - Direction bit high means output line
// - Data write changes only output bits
// - Input reads pins or latched strobe capture
// - Control bit 2 selects input latch
// - Soft reset holds data, direction, port flags clear
// - Soft reset set by reset, cleared by write
// - Strobe edge polarity chosen by control bit 1
// - Strobe edge sets flag; bit 0 enables irq
// - Port flag clears on seen-then-data access
// - Track flag state at last status read
// - Control bit 6 has no function
//
// Decided for this implementation: the APB register port and the register addresses.
`default_nettype none

module pps_parallel_port
    import pps_pkg::*;
#(
    parameter int PORT_W = PPS_PORT_W          // Port line count
) (
    // Clock, reset and enable
    input  wire  logic                  clock,
    input  wire  logic                  reset_n,
    input  wire  logic                  clockEnable,
    // APB slave
    input  wire  logic                  psel,
    input  wire  logic                  penable,
    input  wire  logic                  pwrite,
    input  wire  logic [PPS_ADDR_W-1:0] paddr,
    input  wire  logic [PPS_DATA_W-1:0] pwdata,
    output logic       [PPS_DATA_W-1:0] prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Port lines, split into input, output and enable
    input  wire  logic [PORT_W-1:0]     portLinesIn,
    output logic       [PORT_W-1:0]     portLinesOut,
    output logic       [PORT_W-1:0]     portLinesOe,
    // Strobe and aux control lines
    input  wire  logic                  strobeIrqInput,
    input  wire  logic                  auxControlIn,
    output logic                        auxControlOut,
    output logic                        auxControlOe,
    // Timer core events, same clock
    input  wire  logic                  timerTimeout,
    input  wire  logic                  timerInitStart,
    input  wire  logic                  timerLatchWrite,
    input  wire  logic                  timerCounterRead,
    output logic       [7:0]            timerControl,
    // Interrupt
    output logic                        irqN
);

    // Whole block state in one record
    typedef struct packed {
        logic [7:0]            port_control;            // Port control
        logic [7:0]            timer_control;            // Timer control
        logic [PORT_W-1:0]     ddr;            // Line direction
        logic [PORT_W-1:0]     port_data;            // Output data
        logic [PORT_W-1:0]     latchVal;       // Captured inputs
        logic                  latchFull;      // Capture held
        logic                  timerFlag;      // Timer flag
        logic                  strobeFlag;     // Strobe flag
        logic                  auxFlag;        // Aux flag
        logic                  seenTimer;      // Timer flag at last status read
        logic                  seenStrobe;     // Strobe flag at last status read
        logic                  seenAux;        // Aux flag at last status read
        logic [PORT_W-1:0]     pinSync1;       // Pin sync first stage
        logic [PORT_W-1:0]     pinSync2;       // Pin sync second stage
        logic                  strobeSync1;    // Strobe sync first stage
        logic                  strobeSync2;    // Strobe sync second stage
        logic                  strobePrev;     // Strobe edge history
        logic                  auxSync1;       // Aux sync first stage
        logic                  auxSync2;       // Aux sync second stage
        logic                  auxPrev;        // Aux edge history
        logic                  auxOut;         // Aux line drive level
        logic                  irqN;           // Interrupt, active low
        logic                  pready;         // Access-phase answer
        logic                  pslverr;        // Unmapped address
        logic [PPS_DATA_W-1:0] prdata;         // Read data
    } pps_state_t;

    pps_state_t st;                            // Registered state
    pps_state_t next_st;                       // Next state

    // Decoded bus and event terms
    logic              setupPhase;             // First cycle of a transfer
    logic              accessDone;             // Access completes this edge
    logic              hitStatus;              // Address decodes
    logic              hitControl;
    logic              hitDirection;
    logic              hitData;
    logic              hitTimerCtl;
    logic              mapped;                 // Any register hit
    logic              dataWrite;              // Data register write
    logic              dataRead;               // Data register read
    logic              dataAccess;             // Read or write of data
    logic              statusRead;             // Status register read
    logic              strobeEdge;             // Active strobe transition
    logic              auxEdge;                // Active aux transition
    logic              clrStrobe;              // Seen-then-access clears
    logic              clrAux;
    logic              clrTimer;
    logic              compositeNow;           // Composite from current state
    logic [PORT_W-1:0] pinView;                // Live or latched inputs
    logic [PORT_W-1:0] dataView;               // Data register read value
    logic [7:0]        statusView;             // Status register read value

    // Next-state logic for the whole block
    always_comb begin
        next_st = st;

        // Two-stage synchronisers on the port line, strobe and aux inputs
        next_st.pinSync1    = portLinesIn;
        next_st.pinSync2    = st.pinSync1;
        next_st.strobeSync1 = strobeIrqInput;
        next_st.strobeSync2 = st.strobeSync1;
        next_st.strobePrev  = st.strobeSync2;
        next_st.auxSync1    = auxControlIn;
        next_st.auxSync2    = st.auxSync1;
        next_st.auxPrev     = st.auxSync2;

        // Address decode, one word per register
        hitStatus    = (paddr == OFS_STATUS);
        hitControl   = (paddr == OFS_CONTROL);
        hitDirection = (paddr == OFS_DIRECTION);
        hitData      = (paddr == OFS_DATA);
        hitTimerCtl  = (paddr == OFS_TIMER_CTL);
        mapped = hitStatus | hitControl | hitDirection | hitData | hitTimerCtl;

        // Effects only at the completing access edge
        setupPhase = psel & ~penable;
        accessDone = psel & penable & st.pready;
        dataWrite  = accessDone & pwrite & hitData;
        dataRead   = accessDone & ~pwrite & hitData;
        dataAccess = dataWrite | dataRead;
        statusRead = accessDone & ~pwrite & hitStatus;

        // Edge select, high picks the falling edge
        strobeEdge = st.port_control[PCR_EDGE_NEG] ?
                     (st.strobePrev & ~st.strobeSync2) :
                     (~st.strobePrev & st.strobeSync2);
        // Aux line only raises flags while it is an input
        auxEdge = ~st.port_control[PCR_AUX_DIR] & (st.port_control[PCR_AUX_EDGE] ?
                  (st.auxPrev & ~st.auxSync2) :
                  (~st.auxPrev & st.auxSync2));

        // Read views; a held capture masks live input pins
        pinView = (st.port_control[PCR_LATCH_SEL] & st.latchFull) ?
                  st.latchVal : st.pinSync2;
        dataView = (st.ddr & st.port_data) | (~st.ddr & pinView);
        compositeNow = (st.timerFlag & st.timer_control[TCR_IRQ_EN]) |
                       (st.strobeFlag & st.port_control[PCR_IRQ_EN]) |
                       (st.auxFlag & st.port_control[PCR_AUX_CTL] & ~st.port_control[PCR_AUX_DIR]);
        statusView = {compositeNow, ZERO_NIBBLE,
                      st.auxFlag, st.strobeFlag, st.timerFlag};

        // Bus answer: data sampled in setup, ready in access
        next_st.pready = setupPhase;
        if (setupPhase) begin
            next_st.pslverr = ~mapped;
            next_st.prdata  = ZERO_WORD;
            if (!pwrite) begin
                if (hitStatus) begin
                    next_st.prdata[7:0] = statusView;
                end else if (hitControl) begin
                    next_st.prdata[7:0] = st.port_control;
                end else if (hitDirection) begin
                    next_st.prdata[PORT_W-1:0] = st.ddr;
                end else if (hitData) begin
                    next_st.prdata[PORT_W-1:0] = dataView;
                end else if (hitTimerCtl) begin
                    next_st.prdata[7:0] = st.timer_control;
                end
            end
        end else if (accessDone) begin
            next_st.pslverr = 1'b0;
        end

        // Register writes; status has no write path
        if (accessDone & pwrite) begin
            if (hitControl) begin
                next_st.port_control = pwdata[7:0];
                next_st.port_control[PCR_UNUSED] = 1'b0;
            end
            if (hitTimerCtl) begin
                next_st.timer_control = pwdata[7:0];
            end
            if (hitDirection) begin
                next_st.ddr = pwdata[PORT_W-1:0];
            end
            if (hitData) begin
                // Input bits keep their stored value
                next_st.port_data = (pwdata[PORT_W-1:0] & st.ddr) |
                              (st.port_data & ~st.ddr);
            end
        end

        // Input latch: a read releases, an edge captures if free
        if (dataRead | ~st.port_control[PCR_LATCH_SEL]) begin
            next_st.latchFull = 1'b0;
        end
        if (st.port_control[PCR_LATCH_SEL] & strobeEdge & (~st.latchFull | dataRead)) begin
            next_st.latchVal  = st.pinSync2;
            next_st.latchFull = 1'b1;
        end

        // Port flags: a new edge wins over a same-cycle clear
        clrStrobe = dataAccess & st.seenStrobe;
        clrAux    = dataAccess & st.seenAux;
        next_st.strobeFlag = strobeEdge | (st.strobeFlag & ~clrStrobe);
        next_st.auxFlag    = auxEdge | (st.auxFlag & ~clrAux);
        if (clrStrobe) begin
            next_st.seenStrobe = 1'b0;
        end
        if (clrAux) begin
            next_st.seenAux = 1'b0;
        end

        // Timer flag clears, timeout still wins
        clrTimer = timerInitStart |
                   (timerLatchWrite & st.timer_control[TCR_INTERVAL]) |
                   (timerCounterRead & st.seenTimer);
        next_st.timerFlag = timerTimeout | (st.timerFlag & ~clrTimer);
        if (timerCounterRead & st.seenTimer) begin
            next_st.seenTimer = 1'b0;
        end

        // Snapshot of what the status read returned
        if (statusRead) begin
            next_st.seenTimer  = st.prdata[STS_TIMER];
            next_st.seenStrobe = st.prdata[STS_STROBE];
            next_st.seenAux    = st.prdata[STS_AUX];
        end

        // Timer reset holds the flag low, it overrides a timeout
        if (st.timer_control[TCR_RESET]) begin
            next_st.timerFlag = 1'b0;
            next_st.seenTimer = 1'b0;
        end

        // Soft reset holds the port cleared, other control bits stay
        if (next_st.port_control[PCR_SOFT_RST]) begin
            next_st.ddr        = '0;
            next_st.port_data        = '0;
            next_st.strobeFlag = 1'b0;
            next_st.auxFlag    = 1'b0;
            next_st.seenStrobe = 1'b0;
            next_st.seenAux    = 1'b0;
            next_st.latchFull  = 1'b0;
        end

        // Aux line drive modes
        unique case ({next_st.port_control[PCR_AUX_EDGE], next_st.port_control[PCR_AUX_CTL]})
            2'b11, 2'b10: begin
                // Programmable level
                next_st.auxOut = next_st.port_control[PCR_AUX_CTL];
            end
            2'b01: begin
                // One-cycle low acknowledge after a data access
                next_st.auxOut = ~dataAccess;
            end
            2'b00: begin
                // Follows the strobe flag one cycle later, driven low after it clears
                next_st.auxOut = st.strobeFlag;
            end
        endcase

        // Composite from the next flags and enables
        next_st.irqN = ~((next_st.timerFlag & next_st.timer_control[TCR_IRQ_EN]) |
                         (next_st.strobeFlag & next_st.port_control[PCR_IRQ_EN]) |
                         (next_st.auxFlag & next_st.port_control[PCR_AUX_CTL] &
                          ~next_st.port_control[PCR_AUX_DIR]));
    end

    // State register; soft reset bit comes up set
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st      <= '0;
            st.port_control  <= PCR_RESET_VAL;
            st.timer_control  <= TCR_RESET_VAL;
            st.irqN <= 1'b1;
            st.auxOut <= 1'b1;
        end else if (clockEnable) begin
            st <= next_st;
        end
    end

    // Outputs straight from state
    assign prdata        = st.prdata;
    assign pready        = st.pready;
    assign pslverr       = st.pslverr;
    assign portLinesOut  = st.port_data;
    assign portLinesOe   = st.ddr;
    assign auxControlOut = st.auxOut;
    assign auxControlOe  = st.port_control[PCR_AUX_DIR];
    assign timerControl  = st.timer_control;
    assign irqN          = st.irqN;

    // Checks, frozen cycles are not counted
    default clocking cb @(posedge clock iff clockEnable);
    endclocking
    default disable iff (!reset_n);

    // Status read followed two or three cycles later by a data access
    sequence s_status_saw_strobe;
        statusRead && st.prdata[STS_STROBE];
    endsequence
    sequence s_data_no_edge;
        dataAccess && !strobeEdge;
    endsequence

    property p_composite_set;
        (st.strobeFlag && st.port_control[PCR_IRQ_EN]) || (st.timerFlag && st.timer_control[TCR_IRQ_EN])
            |-> !irqN;
    endproperty
    a_composite_set: assert property (p_composite_set)
        else $error("Enabled flag without interrupt");

    property p_composite_clear;
        !compositeNow |-> irqN && !statusView[STS_COMPOSITE];
    endproperty
    a_composite_clear: assert property (p_composite_clear)
        else $error("Interrupt with no enabled flag");

    property p_timer_reset;
        st.timer_control[TCR_RESET] |=> !st.timerFlag;
    endproperty
    a_timer_reset: assert property (p_timer_reset)
        else $error("Timer flag survived timer reset");

    property p_timer_init;
        timerInitStart && !timerTimeout |=> !st.timerFlag;
    endproperty
    a_timer_init: assert property (p_timer_init)
        else $error("Timer flag survived initialisation");

    property p_latch_write_clear;
        timerLatchWrite && !timerInitStart && !timerTimeout && !st.timer_control[TCR_RESET]
            && !timerCounterRead
            && st.timerFlag |=> st.timerFlag == !$past(st.timer_control[TCR_INTERVAL]);
    endproperty
    a_latch_write_clear: assert property (p_latch_write_clear)
        else $error("Latch write clear wrong for mode");

    property p_counter_read_keep;
        timerCounterRead && !st.seenTimer && st.timerFlag && !timerInitStart
            && !timerLatchWrite && !st.timer_control[TCR_RESET] |=> st.timerFlag;
    endproperty
    a_counter_read_keep: assert property (p_counter_read_keep)
        else $error("Unseen timer flag lost on counter read");

    property p_unused_zero;
        setupPhase && !pwrite && hitStatus |=> prdata[STS_UNUSED_HI:STS_UNUSED_LO] == 0;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("Unused status bits not zero");

    property p_data_write;
        dataWrite && !next_st.port_control[PCR_SOFT_RST] |=>
            portLinesOut == (($past(pwdata[PORT_W-1:0]) & $past(st.ddr)) |
                             ($past(st.port_data) & ~$past(st.ddr)));
    endproperty
    a_data_write: assert property (p_data_write)
        else $error("Data write touched input bits");

    property p_latch_hold;
        st.port_control[PCR_LATCH_SEL] && st.latchFull && !dataRead |=> $stable(st.latchVal);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("Held capture overwritten before read");

    property p_soft_reset;
        st.port_control[PCR_SOFT_RST] |-> portLinesOe == 0 && portLinesOut == 0
            && !st.strobeFlag && !st.auxFlag;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("Port not cleared under soft reset");

    property p_strobe_set;
        strobeEdge && !next_st.port_control[PCR_SOFT_RST] |=> st.strobeFlag;
    endproperty
    a_strobe_set: assert property (p_strobe_set)
        else $error("Strobe edge did not set flag");

    property p_seen_clear;
        s_status_saw_strobe ##[2:3] s_data_no_edge |=> !st.strobeFlag;
    endproperty
    a_seen_clear: assert property (p_seen_clear)
        else $error("Seen strobe flag not cleared by access");

    property p_unseen_keep;
        dataAccess && !st.seenStrobe && st.strobeFlag && !next_st.port_control[PCR_SOFT_RST]
            |=> st.strobeFlag;
    endproperty
    a_unseen_keep: assert property (p_unseen_keep)
        else $error("Unseen strobe flag cleared by access");

endmodule : pps_parallel_port

`default_nettype wire

// File: pps_pin_model.sv
// Purpose: Far-side model of the eight port lines
// Assumes: A line driven by the port shows the port's own level
// Notes:   Undriven lines show the level the bench asks for
`default_nettype none

module pps_pin_model (
    // Port side
    input  wire  logic [7:0] portLinesOut,
    input  wire  logic [7:0] portLinesOe,
    // Bench side
    input  wire  logic [7:0] pinDrive,
    // Resolved wire level
    output logic       [7:0] portLinesIn
);
    timeunit 1ns;
    timeprecision 1ns;

    // Port drive wins where enabled, the peripheral drives the rest
    assign portLinesIn = (portLinesOe & portLinesOut) | (~portLinesOe & pinDrive);
endmodule : pps_pin_model

`default_nettype wire

// File: pps_pkg.sv
// Purpose: Shared constants for the parallel port and combined status block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Register map, field positions and reset values live here
`default_nettype none

package pps_pkg;

    // Widths
    localparam int PPS_PORT_W = 8;               // Port line count
    localparam int PPS_ADDR_W = 8;               // APB address width
    localparam int PPS_DATA_W = 32;              // APB data width

    // Register byte offsets
    localparam logic [PPS_ADDR_W-1:0] OFS_STATUS    = 8'h00;
    localparam logic [PPS_ADDR_W-1:0] OFS_CONTROL   = 8'h04;
    localparam logic [PPS_ADDR_W-1:0] OFS_DIRECTION = 8'h08;
    localparam logic [PPS_ADDR_W-1:0] OFS_DATA      = 8'h0C;
    localparam logic [PPS_ADDR_W-1:0] OFS_TIMER_CTL = 8'h10;

    // Combined status fields
    localparam int STS_TIMER     = 0;            // Timer flag
    localparam int STS_STROBE    = 1;            // Strobe line flag
    localparam int STS_AUX       = 2;            // Aux line flag
    localparam int STS_UNUSED_LO = 3;            // Unused field low end
    localparam int STS_UNUSED_HI = 6;            // Unused field high end
    localparam int STS_COMPOSITE = 7;            // Composite flag

    // Port control fields
    localparam int PCR_IRQ_EN    = 0;            // Strobe irq enable
    localparam int PCR_EDGE_NEG  = 1;            // Strobe falling edge select
    localparam int PCR_LATCH_SEL = 2;            // Input latch select
    localparam int PCR_AUX_CTL   = 3;            // Aux irq enable / output level
    localparam int PCR_AUX_EDGE  = 4;            // Aux edge / output mode
    localparam int PCR_AUX_DIR   = 5;            // Aux line is an output
    localparam int PCR_UNUSED    = 6;            // No function
    localparam int PCR_SOFT_RST  = 7;            // Port soft reset

    // Timer control fields
    localparam int TCR_RESET     = 0;            // Timer internal reset
    localparam int TCR_INTERVAL  = 3;            // Time-interval mode
    localparam int TCR_IRQ_EN    = 6;            // Timer irq enable

    // Reset values
    localparam logic [7:0] PCR_RESET_VAL = 8'h80;
    localparam logic [7:0] TCR_RESET_VAL = 8'h00;
    localparam logic [7:0] ZERO_BYTE     = 8'h00;
    localparam logic [3:0] ZERO_NIBBLE   = 4'h0;
    localparam logic [PPS_DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

endpackage : pps_pkg

`default_nettype wire

// File: tb.sv
// Purpose: Self-checking bench for the parallel port and combined status
// Assumes: Zero-wait APB slave, bench drives timer events as pulses
// Notes:   Aux line and clock enable are held constant
`default_nettype none

module tb
    import pps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock, resetN, psel, penable, pwrite, pready, pslverr, strobe, irqN, er;
    logic        auxOut, auxOe;            // Aux line drive and enable
    logic [7:0]  paddr, pinDrive, pinsIn, portOut, portOe, tctl;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  tev;                      // Timer events: timeout, init, latch, count read
    int          errorCnt, checksDone;

    pps_parallel_port dut_u (.clock(clock), .reset_n(resetN), .clockEnable(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .portLinesIn(pinsIn),
        .portLinesOut(portOut), .portLinesOe(portOe), .strobeIrqInput(strobe),
        .auxControlIn(1'b0), .auxControlOut(auxOut), .auxControlOe(auxOe),
        .timerTimeout(tev[0]), .timerInitStart(tev[1]), .timerLatchWrite(tev[2]),
        .timerCounterRead(tev[3]),
        .timerControl(tctl), .irqN(irqN));
    pps_pin_model pin_u (.portLinesOut(portOut), .portLinesOe(portOe),
        .pinDrive(pinDrive), .portLinesIn(pinsIn));

    // Free-running 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Verdict and end of run
    task automatic stopTest();
        $display("errors %0d checks %0d", errorCnt, checksDone);
        if (errorCnt == 0 && checksDone > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stopTest

    task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errorCnt++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    // One APB transfer; request held until pready is seen high
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (int i = 0; i <= 20; i++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
            if (i == 20) begin
                errorCnt++;
                stopTest();
            end
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic rdChk(string n, logic [7:0] a, logic [31:0] exp);
        apb(1'b0, a, ZERO_WORD);
        check(n, rd, exp);
    endtask : rdChk

    // Settle registered outputs, sample off the edge
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask : settle

    task automatic pulse(int i);
        @(posedge clock);
        tev[i] <= 1'b1;
        @(posedge clock);
        tev <= 4'h0;
    endtask : pulse

    // Reset values, unmapped access, soft reset holding direction clear
    task automatic testReset();
        rdChk("control", OFS_CONTROL, 32'h0000_0080);
        rdChk("status", OFS_STATUS, 32'h0000_0000);
        apb(1'b0, 8'h14, ZERO_WORD);
        check("unmapped err", {31'h0, er}, 32'h0000_0001);
        apb(1'b1, OFS_CONTROL, 32'h0000_00F0);
        rdChk("ctl bit6", OFS_CONTROL, 32'h0000_00B0);
        check("aux mode", {30'h0, auxOe, auxOut}, 32'h0000_0002);
        apb(1'b1, OFS_DIRECTION, 32'h0000_00FF);
        rdChk("dir held", OFS_DIRECTION, 32'h0000_0000);
    endtask : testReset

    // Mixed direction: write touches outputs only, inputs read pins
    task automatic testPort();
        apb(1'b1, OFS_CONTROL, ZERO_WORD);
        apb(1'b1, OFS_DIRECTION, 32'h0000_000F);
        apb(1'b1, OFS_DATA, 32'h0000_00A5);
        settle();
        check("oe", {24'h0, portOe}, 32'h0000_000F);
        check("out", {24'h0, portOut}, 32'h0000_0005);
        rdChk("data", OFS_DATA, 32'h0000_0035);
    endtask : testPort

    // Strobe flag, composite, irq and seen-then-access clearing
    task automatic testStrobe();
        apb(1'b1, OFS_CONTROL, 32'h0000_0001);
        strobe <= 1'b1;
        settle();
        check("irq low", {31'h0, irqN}, 32'h0000_0000);
        rdChk("status set", OFS_STATUS, 32'h0000_0082);
        apb(1'b0, OFS_DATA, ZERO_WORD);
        rdChk("status clr", OFS_STATUS, 32'h0000_0000);
        settle();
        check("irq high", {31'h0, irqN}, 32'h0000_0001);
    endtask : testStrobe

    // Falling-edge capture into the latch, unseen flag survives access
    task automatic testLatch();
        apb(1'b1, OFS_CONTROL, 32'h0000_0006);
        strobe <= 1'b0;
        settle();
        @(posedge clock);
        pinDrive <= 8'hC0;
        settle();
        check("irq masked", {31'h0, irqN}, 32'h0000_0001);
        rdChk("latched", OFS_DATA, 32'h0000_0035);
        rdChk("live", OFS_DATA, 32'h0000_00C5);
        rdChk("unseen kept", OFS_STATUS, 32'h0000_0002);
        apb(1'b0, OFS_DATA, ZERO_WORD);
        rdChk("seen clr", OFS_STATUS, 32'h0000_0000);
    endtask : testLatch

    // External reset mid-run clears timer flag and sets soft reset
    task automatic testExtReset();
        apb(1'b1, OFS_TIMER_CTL, ZERO_WORD);
        pulse(0);
        rdChk("tmr pre", OFS_STATUS, 32'h0000_0001);
        resetN <= 1'b0;
        repeat (2) @(posedge clock);
        resetN <= 1'b1;
        check("tctl rst", {24'h0, tctl}, ZERO_WORD);
        rdChk("control rst", OFS_CONTROL, 32'h0000_0080);
        rdChk("status rst", OFS_STATUS, ZERO_WORD);
    endtask : testExtReset

    // Timer flag: enable after set, guarded count read, clearing events
    task automatic testTimer();
        pulse(0);
        pulse(3);
        rdChk("tmr kept", OFS_STATUS, 32'h0000_0001);
        check("irq off", {31'h0, irqN}, 32'h0000_0001);
        apb(1'b1, OFS_TIMER_CTL, 32'h0000_0040);
        settle();
        check("irq late", {31'h0, irqN}, 32'h0000_0000);
        pulse(3);
        rdChk("tmr read", OFS_STATUS, 32'h0000_0000);
        pulse(0);
        pulse(1);
        rdChk("tmr init", OFS_STATUS, 32'h0000_0000);
        apb(1'b1, OFS_TIMER_CTL, 32'h0000_0048);
        pulse(0);
        pulse(2);
        rdChk("tmr latch", OFS_STATUS, 32'h0000_0000);
        check("tctl", {24'h0, tctl}, 32'h0000_0048);
        apb(1'b1, OFS_TIMER_CTL, 32'h0000_0049);
        pulse(0);
        rdChk("tmr reset", OFS_STATUS, 32'h0000_0000);
    endtask : testTimer

    // Main sequence
    initial begin
        resetN = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = ZERO_WORD; pinDrive = 8'h30; strobe = 1'b0; tev = 4'h0;
        errorCnt = 0; checksDone = 0;
        repeat (10) @(posedge clock);
        resetN <= 1'b1;
        testReset();
        testPort();
        testStrobe();
        testLatch();
        testTimer();
        testExtReset();
        stopTest();
    end
endmodule : tb

`default_nettype wire
